/* File: include/console_pkg.sv */
// constants for the boot serial console and download port
//-----------------------------------------------------------------
// Operation
//-----------------------------------------------------------------
package console_pkg;
    localparam int unsigned CLOCK_HZ = 100000000;
    localparam int unsigned BOOT_BAUD = 57600;
    localparam int unsigned MAX_BAUD = 115200;
    localparam int unsigned DIV_WIDTH = 16;
    // rounded integer divider for the power-on rate
    localparam logic [15:0] BOOT_DIVISOR = 16'((CLOCK_HZ + BOOT_BAUD / 2) / BOOT_BAUD);
    localparam logic [15:0] MIN_DIVISOR = 16'(CLOCK_HZ / MAX_BAUD);
    localparam int unsigned BANNER_LEN = 8;
    localparam logic [7:0] HANDSHAKE_REQ = 8'h05;
    localparam logic [7:0] HANDSHAKE_ACK = 8'h06;
    localparam logic [7:0] IMAGE_LEN_BYTES = 8'h04;
    localparam logic [3:0] FRAME_BITS = 4'h9;
    typedef enum logic [2:0] {
        ST_SETUP,
        ST_BANNER,
        ST_WAIT_HS,
        ST_SEND_ACK,
        ST_LOAD,
        ST_DONE,
        ST_CONSOLE,
        ST_GENERAL
    } boot_state_e;
endpackage

/* File: verilog/serial_tx_rx.sv */
// one 8N1 uart transmitter and receiver with integer divider
`timescale 1ns/1ns
`default_nettype none
module serial_tx_rx (
    input wire logic clock_in, // system clock
    input wire logic rst_n_in, // synchronous reset, active low
    input wire logic enable_in, // clock enable
    input wire logic [15:0] divisor_in, // clocks per bit
    input wire logic tx_valid_in, // byte offered
    input wire logic [7:0] tx_data_in, // byte to send
    output logic tx_ready_out, // transmitter idle
    output logic tx_line_out, // serial out, idle high
    input wire logic rx_line_in, // serial in
    output logic rx_valid_out, // one-cycle received pulse
    output logic [7:0] rx_data_out // received byte
);
    import console_pkg::*;
    logic [15:0] tx_count;
    logic [3:0] tx_bits;
    logic [8:0] tx_shift;
    logic [15:0] rx_count;
    logic [3:0] rx_bits;
    logic [7:0] rx_shift;
    logic rx_busy;
    wire tx_tick = (tx_count == 16'h0000);
    wire rx_tick = (rx_count == 16'h0000);
    wire [15:0] half_div = {1'b0, divisor_in[15:1]};
    assign tx_ready_out = (tx_bits == 4'h0);

    //-----------------------------------------------------------------
    // transmitter
    //-----------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            tx_bits <= 4'h0;
            tx_count <= 16'h0000;
            tx_shift <= 9'h1FF;
            tx_line_out <= 1'b1;
        end
        else if (enable_in)
        begin
            if (tx_bits == 4'h0)
            begin
                if (tx_valid_in)
                begin
                    tx_line_out <= 1'b0;
                    tx_shift <= {1'b1, tx_data_in};
                    tx_bits <= FRAME_BITS + 4'h1;
                    tx_count <= divisor_in - 16'h0001;
                end
            end
            else if (tx_tick)
            begin
                tx_line_out <= tx_shift[0];
                tx_shift <= {1'b1, tx_shift[8:1]};
                tx_bits <= tx_bits - 4'h1;
                tx_count <= divisor_in - 16'h0001;
            end
            else
            begin
                tx_count <= tx_count - 16'h0001;
            end
        end
    end

    //-----------------------------------------------------------------
    // receiver, samples mid-bit
    //-----------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            rx_busy <= 1'b0;
            rx_bits <= 4'h0;
            rx_count <= 16'h0000;
            rx_shift <= 8'h00;
            rx_valid_out <= 1'b0;
            rx_data_out <= 8'h00;
        end
        else if (enable_in)
        begin
            rx_valid_out <= 1'b0;
            if (!rx_busy)
            begin
                if (!rx_line_in)
                begin
                    rx_busy <= 1'b1;
                    rx_bits <= FRAME_BITS + 4'h1;
                    rx_count <= half_div;
                end
            end
            else if (rx_tick)
            begin
                rx_count <= divisor_in - 16'h0001;
                rx_bits <= rx_bits - 4'h1;
                if (rx_bits == FRAME_BITS + 4'h1)
                begin
                    if (rx_line_in)
                    begin
                        rx_busy <= 1'b0;
                    end
                end
                else if (rx_bits == 4'h1)
                begin
                    rx_busy <= 1'b0;
                    if (rx_line_in)
                    begin
                        rx_valid_out <= 1'b1;
                        rx_data_out <= rx_shift;
                    end
                end
                else
                begin
                    rx_shift <= {rx_line_in, rx_shift[7:1]};
                end
            end
            else
            begin
                rx_count <= rx_count - 16'h0001;
            end
        end
    end
endmodule // serial_tx_rx
`default_nettype wire

/* File: verilog/boot_serial_console_loader.sv */
// boot console, strap-selected download and general-purpose serial port
`timescale 1ns/1ns
`default_nettype none
module boot_serial_console_loader #(
    parameter int unsigned BANNER_BYTES = console_pkg::BANNER_LEN,
    parameter logic [7:0] IMAGE_BYTES = console_pkg::IMAGE_LEN_BYTES
) (
    input wire logic clock_in, // system clock 100 MHz
    input wire logic rst_n_in, // power-on reset, active low
    input wire logic enable_in, // clock enable
    input wire logic download_strap_n_in, // low selects download
    input wire logic console_rx_line, // serial from host
    output logic console_tx_line, // serial to host
    input wire logic stdout_valid_in, // standard output char offered
    input wire logic [7:0] stdout_data_in, // standard output char
    output logic stdout_ready_out, // char taken
    output logic stdin_valid_out, // one-cycle received char
    output logic [7:0] stdin_data_out, // received char
    input wire logic general_mode_in, // stored program owns the port
    input wire logic cfg_write_in, // load new divisor
    input wire logic [15:0] cfg_divisor_in, // new clocks per bit
    output logic flash_write_out, // one-cycle flash write
    output logic [7:0] flash_addr_out, // flash byte address
    output logic [7:0] flash_data_out, // flash byte
    output logic download_mode_out, // latched strap mode
    output logic download_done_out, // image stored
    output logic run_program_out // execute stored program
);
    import console_pkg::*;
    boot_state_e state;
    boot_state_e next_state;
    logic strap_taken;
    logic [15:0] divisor;
    logic [7:0] index;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_ready;
    logic rx_valid;
    logic [7:0] rx_data;
    logic [7:0] banner_char;

    // banner byte lookup
    function automatic logic [7:0] banner_rom(input logic [7:0] i);
        case (i[2:0])
            3'h0: banner_rom = 8'h42;
            3'h1: banner_rom = 8'h4F;
            3'h2: banner_rom = 8'h4F;
            3'h3: banner_rom = 8'h54;
            3'h4: banner_rom = 8'h20;
            3'h5: banner_rom = 8'h4F;
            3'h6: banner_rom = 8'h4B;
            default: banner_rom = 8'h0A;
        endcase
    endfunction

    //-----------------------------------------------------------------
    // transmit source selection
    //-----------------------------------------------------------------
    wire in_banner = (state == ST_BANNER);
    wire in_console = (state == ST_CONSOLE);
    wire in_general = (state == ST_GENERAL);
    wire last_banner = (index == 8'(BANNER_BYTES - 1));
    assign banner_char = banner_rom(index);
    assign tx_valid = in_banner
        || (state == ST_SEND_ACK)
        || ((in_console || in_general) && stdout_valid_in);
    assign tx_data = in_banner ? banner_char
        : (state == ST_SEND_ACK) ? HANDSHAKE_ACK : stdout_data_in;
    assign stdout_ready_out = (in_console || in_general) && tx_ready;
    // general mode passes application data, console mode passes stdin
    assign stdin_valid_out = (in_console || in_general) && rx_valid;
    assign stdin_data_out = rx_data;
    assign run_program_out = in_console || in_general;
    assign download_done_out = (state == ST_DONE);

    serial_tx_rx uart (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .enable_in(enable_in),
        .divisor_in(divisor),
        .tx_valid_in(tx_valid),
        .tx_data_in(tx_data),
        .tx_ready_out(tx_ready),
        .tx_line_out(console_tx_line),
        .rx_line_in(console_rx_line),
        .rx_valid_out(rx_valid),
        .rx_data_out(rx_data)
    );

    //-----------------------------------------------------------------
    // boot sequencer
    //-----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            ST_SETUP: next_state = strap_taken ? ST_BANNER : ST_SETUP;
            ST_BANNER:
            begin
                if (tx_ready && last_banner)
                begin
                    next_state = download_mode_out ? ST_WAIT_HS : ST_CONSOLE;
                end
            end
            ST_WAIT_HS:
            begin
                if (rx_valid && rx_data == HANDSHAKE_REQ)
                begin
                    next_state = ST_SEND_ACK;
                end
            end
            ST_SEND_ACK: next_state = tx_ready ? ST_LOAD : ST_SEND_ACK;
            ST_LOAD:
            begin
                if (rx_valid && index == IMAGE_BYTES - 8'h01)
                begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: next_state = ST_DONE;
            ST_CONSOLE: next_state = general_mode_in ? ST_GENERAL : ST_CONSOLE;
            ST_GENERAL: next_state = ST_GENERAL;
            default: next_state = ST_SETUP;
        endcase
    end

    //-----------------------------------------------------------------
    // qualified events
    //-----------------------------------------------------------------
    wire in_load = (state == ST_LOAD);
    wire banner_take = in_banner && tx_ready;
    wire load_take = in_load && rx_valid;
    // a smaller divisor would exceed the fastest supported rate
    wire cfg_accept = in_general && cfg_write_in && (cfg_divisor_in >= MIN_DIVISOR);
    wire [7:0] next_index = banner_take ? (last_banner ? 8'h00 : index + 8'h01)
        : load_take ? index + 8'h01 : index;

    //-----------------------------------------------------------------
    // sequencer state
    //-----------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            state <= ST_SETUP;
        end
        else if (enable_in)
        begin
            state <= next_state;
        end
    end

    //-----------------------------------------------------------------
    // strap latch, taken on the first enabled edge only
    //-----------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            strap_taken <= 1'b0;
            download_mode_out <= 1'b0;
        end
        else if (enable_in && !strap_taken)
        begin
            strap_taken <= 1'b1;
            download_mode_out <= !download_strap_n_in;
        end
    end

    //-----------------------------------------------------------------
    // bit divisor
    //-----------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            divisor <= BOOT_DIVISOR;
        end
        else if (enable_in && cfg_accept)
        begin
            divisor <= cfg_divisor_in;
        end
    end

    //-----------------------------------------------------------------
    // banner and image byte index
    //-----------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            index <= 8'h00;
        end
        else if (enable_in)
        begin
            index <= next_index;
        end
    end

    //-----------------------------------------------------------------
    // flash write port
    //-----------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            flash_write_out <= 1'b0;
            flash_addr_out <= 8'h00;
            flash_data_out <= 8'h00;
        end
        else if (enable_in)
        begin
            flash_write_out <= load_take;
            if (load_take)
            begin
                flash_addr_out <= index;
                flash_data_out <= rx_data;
            end
        end
    end
endmodule // boot_serial_console_loader
`default_nettype wire

/* File: verif/console_checker.sv */
// port assertions for the boot console and download port
`timescale 1ns/1ns
`default_nettype none
module console_checker (
    input wire logic clock_in, // clock
    input wire logic rst_n_in, // sync reset
    input wire logic stdout_valid_in, // char offered
    input wire logic stdout_ready_out, // char taken
    input wire logic console_tx_line, // serial out
    input wire logic stdin_valid_out, // char received
    input wire logic flash_write_out, // flash write
    input wire logic download_mode_out, // latched strap
    input wire logic download_done_out, // image stored
    input wire logic run_program_out // run stored program
);
    //-------------------------------------------------------------
    // properties
    //-------------------------------------------------------------
    logic take;
    assign take = stdout_valid_in && stdout_ready_out;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    AST_MODE_HOLD: assert property (
        $past(rst_n_in, 2) && $past(rst_n_in) |-> $stable(download_mode_out))
        else $error("strap mode changed after power-on");
    AST_FLASH_MODE: assert property (
        flash_write_out |-> download_mode_out)
        else $error("flash written outside download");
    AST_DONE_MODE: assert property (
        download_done_out |-> download_mode_out)
        else $error("done without download");
    AST_DONE_QUIET: assert property (
        $past(download_done_out) |-> !flash_write_out)
        else $error("flash written after done");
    AST_STDIN_PULSE: assert property (
        stdin_valid_out |=> !stdin_valid_out)
        else $error("stdin pulse too long");
    AST_RUN_MODE: assert property (
        run_program_out |-> !download_mode_out)
        else $error("program runs in download mode");
    AST_NO_STDOUT_DL: assert property (
        download_mode_out && !download_done_out |-> !stdout_ready_out)
        else $error("stdout taken during download");
    AST_START_BIT: assert property (
        take |=> (!console_tx_line) [*8])
        else $error("start bit missing after take");
    AST_READY_DROP: assert property (
        take |=> (!stdout_ready_out) [*8])
        else $error("ready stays high while sending");
endmodule // console_checker
bind boot_serial_console_loader console_checker i_console_checker (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .stdout_valid_in(stdout_valid_in),
    .stdout_ready_out(stdout_ready_out), .console_tx_line(console_tx_line),
    .stdin_valid_out(stdin_valid_out), .flash_write_out(flash_write_out),
    .download_mode_out(download_mode_out), .download_done_out(download_done_out),
    .run_program_out(run_program_out));
`default_nettype wire

/* File: verif/host_serial_model.sv */
// host side of the console link: 8N1 sender and receiver
`timescale 1ns/1ns
`default_nettype none
module host_serial_model (
    input wire logic clock_in, // system clock
    input wire logic from_dev_in, // device serial out
    output logic to_dev_out, // device serial in
    output logic got_out, // one-cycle byte received
    output logic [7:0] byte_out // byte received
);
    //-------------------------------------------------------------
    // link
    //-------------------------------------------------------------
    int unsigned div = 1736;
    logic [7:0] rx;
    initial
    begin
        to_dev_out = 1'b1;
        got_out = 1'b0;
        byte_out = 8'h00;
    end
    // keys and download request, lsb first, line idles high
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            to_dev_out <= f[i];
            repeat (div) @(posedge clock_in);
        end
    endtask
    // mid-bit sampling, frames with a bad stop bit are dropped
    always
    begin
        @(negedge from_dev_in);
        repeat (div / 2) @(posedge clock_in);
        for (int i = 0; i < 8; i++)
        begin
            repeat (div) @(posedge clock_in);
            rx[i] = from_dev_in;
        end
        repeat (div) @(posedge clock_in);
        if (from_dev_in === 1'b1)
        begin
            byte_out <= rx;
            got_out <= 1'b1;
            @(posedge clock_in);
            got_out <= 1'b0;
        end
    end
endmodule // host_serial_model
`default_nettype wire

/* File: verif/test_boot_serial_console_loader.sv */
// self-checking bench for the boot console and download port
`timescale 1ns/1ns
`default_nettype none
module test_boot_serial_console_loader;
    import console_pkg::*;
    //-------------------------------------------------------------
    // bench
    //-------------------------------------------------------------
    logic clock_in, rst_n_in, strap_n, rx_line, tx_line, valid, ready, gen, cfg_wr;
    logic stdin_v, flash_wr, mode, done, run, got;
    logic [7:0] data, stdin_d, flash_a, flash_d, host_b, c;
    logic [15:0] cfg_div;
    logic [9:0] exp_q[$];
    int failures = 0;
    int samples_checked = 0;
    boot_serial_console_loader #(.BANNER_BYTES(1), .IMAGE_BYTES(8'h01))
        i_boot_serial_console_loader (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .enable_in(1'b1),
        .download_strap_n_in(strap_n), .console_rx_line(rx_line),
        .console_tx_line(tx_line), .stdout_valid_in(valid), .stdout_data_in(data),
        .stdout_ready_out(ready), .stdin_valid_out(stdin_v), .stdin_data_out(stdin_d),
        .general_mode_in(gen), .cfg_write_in(cfg_wr), .cfg_divisor_in(cfg_div),
        .flash_write_out(flash_wr), .flash_addr_out(flash_a), .flash_data_out(flash_d),
        .download_mode_out(mode), .download_done_out(done), .run_program_out(run));
    host_serial_model i_host_serial_model (.clock_in(clock_in), .from_dev_in(tx_line),
        .to_dev_out(rx_line), .got_out(got), .byte_out(host_b));
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic compare(input logic [9:0] seen);
        if (exp_q.size() == 0)
            check("unexpected", seen, 10'h3FF);
        else
            check("result", seen, exp_q.pop_front());
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic drain;
        repeat (40000) if (exp_q.size() != 0) @(posedge clock_in);
        if (exp_q.size() != 0)
        begin
            failures++;
            $display("CHECK FAILED drain expected %0d seen %0d", 0, exp_q.size());
            exp_q.delete();
        end
    endtask
    task automatic power_on(input logic s);
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        strap_n <= s;
        i_host_serial_model.div = 1736;
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        exp_q.push_back({2'h0, 8'h42});
    endtask
    task automatic offer(input logic [7:0] b);
        repeat (40000) if (ready !== 1'b1) @(negedge clock_in);
        @(posedge clock_in);
        valid <= 1'b1;
        data <= b;
        exp_q.push_back({2'h0, b});
        @(posedge clock_in);
        valid <= 1'b0;
    endtask
    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    initial
    begin
        repeat (105000) @(posedge clock_in);
        failures++;
        give_verdict();
    end
    always @(negedge clock_in)
    begin
        if (got === 1'b1)
            compare({2'h0, host_b});
        if (stdin_v === 1'b1)
            compare({2'h1, stdin_d});
        if (flash_wr === 1'b1)
        begin
            compare({2'h2, flash_d});
            check("addr", {2'h0, flash_a}, 10'h000);
        end
    end
    initial
    begin
        {valid, gen, cfg_wr, data, cfg_div} = '0;
        strap_n = 1'b1;
        rst_n_in = 1'b0;
        void'($urandom(29));
        power_on(1'b1);
        drain();
        strap_n <= 1'b0;
        check("mode", {9'h000, mode}, 10'h000);
        check("run", {9'h000, run}, 10'h001);
        c = 8'($urandom);
        exp_q.push_back({2'h1, c});
        fork
            i_host_serial_model.send(c);
            begin
                repeat (100) @(posedge clock_in);
                offer(8'($urandom));
            end
        join
        drain();
        gen <= 1'b1;
        cfg_div <= 16'h0364 + 16'($urandom % 64);
        @(posedge clock_in);
        cfg_wr <= 1'b1;
        @(posedge clock_in);
        cfg_wr <= 1'b0;
        i_host_serial_model.div = cfg_div;
        offer(8'($urandom));
        drain();
        check("mode", {9'h000, mode}, 10'h000);
        gen <= 1'b0;
        power_on(1'b0);
        valid <= 1'b1;
        exp_q.push_back({2'h0, HANDSHAKE_ACK});
        // host utility is already talking while the banner goes out
        i_host_serial_model.send(HANDSHAKE_REQ);
        drain();
        check("mode", {9'h000, mode}, 10'h001);
        valid <= 1'b0;
        c = 8'($urandom);
        exp_q.push_back({2'h2, c});
        i_host_serial_model.send(c);
        drain();
        check("done", {9'h000, done}, 10'h001);
        give_verdict();
    end
endmodule // test_boot_serial_console_loader
`default_nettype wire
